// ---- rtl/cmp_irq_pkg.sv ----
package cmp_irq_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_IRQ_EN_LSB = 1;
  localparam int CTRL_EDGE_LSB = 5;
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_FLAG_LSB = 4;
  localparam int IRQ_HIGH_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- rtl/comparator_irq_control.sv ----
// Overview of operation
// - comparators powered only while enable bit set
// - one interrupt output combines all channels
// - control bits 4..1 gate channel interrupts
// - control bit 7 picks edge, channels 2,3
// - bits 6,5 pick edge, channels 1,0
// - status 3..0 read live comparator outputs
// - status 7..4 sticky flags, cleared by read
// - irq always goes to high-priority bit 2
// - all control and status bits reset to zero
`timescale 1ns/1ns
`default_nettype none
module comparator_irq_control
  import cmp_irq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // axi4-lite write
  input wire logic [cmp_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [cmp_irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog comparators
  input wire logic [cmp_irq_pkg::NUM_CH-1:0] comparator_out,
  output logic comparator_power_en,
  // interrupt manager
  output logic irq_request,
  output logic [7:0] high_priority_irq_vector
);
  import cmp_irq_pkg::*;

  typedef struct packed {
    logic [7:0] control;
    logic [NUM_CH-1:0] sync1;
    logic [NUM_CH-1:0] sync2;
    logic [NUM_CH-1:0] live;
    logic [NUM_CH-1:0] flags;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s s_q, s_d;

  function automatic logic [NUM_CH-1:0] edge_select(input logic [7:0] ctrl);
    edge_select = {ctrl[CTRL_EDGE_LSB+2], ctrl[CTRL_EDGE_LSB+2], ctrl[CTRL_EDGE_LSB+1], ctrl[CTRL_EDGE_LSB]};
  endfunction

  // only the two documented offsets decode; anything else answers with an error
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    reg_mapped = (a == ADDR_STATUS) || (a == ADDR_CONTROL);
  endfunction

  logic [NUM_CH-1:0] rise, fall, hit, irq_en;
  logic status_read;

  assign irq_en = s_q.control[CTRL_IRQ_EN_LSB +: NUM_CH];
  assign rise = s_q.sync2 & ~s_q.live;
  assign fall = ~s_q.sync2 & s_q.live;
  // rising when select bit is 1, else falling
  assign hit = ((rise & edge_select(s_q.control)) | (fall & ~edge_select(s_q.control)))
             & irq_en & {NUM_CH{s_q.control[CTRL_ENABLE_BIT]}};
  assign status_read = s_axi_arvalid && !s_q.rvalid && s_axi_araddr == ADDR_STATUS;

  always_comb begin
    s_d = s_q;
    // second stage only reads first; the analog outputs are asynchronous
    s_d.sync1 = comparator_out;
    s_d.sync2 = s_q.sync1;
    // off comparators read as zero so no edge is seen while disabled
    s_d.live = s_q.control[CTRL_ENABLE_BIT] ? s_q.sync2 : '0;
    if (!s_q.control[CTRL_ENABLE_BIT]) begin
      s_d.live = '0;
    end
    // set wins over the clear of a read in the same cycle
    s_d.flags = (status_read ? '0 : s_q.flags) | hit;
    // write channels
    if (s_axi_awvalid && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (s_q.aw_addr == ADDR_CONTROL) begin
        if (s_q.w_strb[0]) begin
          s_d.control = s_q.w_data[7:0];
        end
      end else if (!reg_mapped(s_q.aw_addr)) begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // read channel
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      unique case (s_axi_araddr)
        ADDR_STATUS: begin
          s_d.rdata[STAT_OUT_LSB +: NUM_CH] = s_q.live;
          s_d.rdata[STAT_FLAG_LSB +: NUM_CH] = s_q.flags;
        end
        ADDR_CONTROL: s_d.rdata[7:0] = s_q.control;
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.control <= CONTROL_RESET;
      s_q.flags <= FLAGS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_got;
  assign s_axi_wready = !s_q.w_got;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign comparator_power_en = s_q.control[CTRL_ENABLE_BIT];
  assign irq_request = |s_q.flags;
  // level request held until software reads the status register
  always_comb begin
    high_priority_irq_vector = 8'h00;
    high_priority_irq_vector[IRQ_HIGH_BIT] = |s_q.flags;
  end

  chk_power_follows_enable: assert property (
    @(posedge clock) disable iff (rst)
    comparator_power_en == s_q.control[0])
    else $error("power enable wrong");

  chk_irq_combines_flags: assert property (
    @(posedge clock) disable iff (rst)
    irq_request == (s_q.flags != 4'h0))
    else $error("irq not flag or");

  chk_disabled_no_flag: assert property (
    @(posedge clock) disable iff (rst)
    (!s_q.control[1] && !(status_read == 1'b0 && s_q.flags[0])) |=> !(s_q.flags[0] && !$past(s_q.flags[0])))
    else $error("disabled channel 0 flagged");

  chk_flag_needs_hit: assert property (
    @(posedge clock) disable iff (rst)
    1'b1 |=> (s_q.flags & ~$past(s_q.flags) & ~$past(hit)) == 4'h0)
    else $error("flag set without event");

  chk_rise_ch3_sets: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.control[7] && s_q.control[4] && s_q.control[0] && s_q.sync2[3] && !s_q.live[3]) |=> s_q.flags[3])
    else $error("rise on ch3 lost");

  chk_rise_ch2_sets: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.control[7] && s_q.control[3] && s_q.control[0] && s_q.sync2[2] && !s_q.live[2]) |=> s_q.flags[2])
    else $error("rise on ch2 lost");

  chk_wrong_edge_ch3: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.control[7] && fall[3]) |-> !hit[3])
    else $error("fall on ch3 taken");

  chk_wrong_edge_ch2: assert property (
    @(posedge clock) disable iff (rst)
    (!s_q.control[7] && rise[2]) |-> !hit[2])
    else $error("rise on ch2 taken");

  chk_fall_ch0_sets: assert property (
    @(posedge clock) disable iff (rst)
    (!s_q.control[5] && s_q.control[1] && s_q.control[0] && !s_q.sync2[0] && s_q.live[0]) |=> s_q.flags[0])
    else $error("fall on ch0 lost");

  chk_fall_ch1_sets: assert property (
    @(posedge clock) disable iff (rst)
    (!s_q.control[6] && s_q.control[2] && s_q.control[0] && !s_q.sync2[1] && s_q.live[1]) |=> s_q.flags[1])
    else $error("fall on ch1 lost");

  chk_wrong_edge_ch1: assert property (
    @(posedge clock) disable iff (rst)
    (!s_q.control[6] && rise[1]) |-> !hit[1])
    else $error("rise on ch1 taken");

  chk_wrong_edge_ch0: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.control[5] && fall[0]) |-> !hit[0])
    else $error("fall on ch0 taken");

  chk_disabled_no_hit: assert property (
    @(posedge clock) disable iff (rst)
    !s_q.control[0] |-> hit == 4'h0)
    else $error("event while disabled");

  chk_disabled_live_zero: assert property (
    @(posedge clock) disable iff (rst)
    !s_q.control[0] |=> s_q.live == 4'h0)
    else $error("live not zero while off");

  chk_read_live_bits: assert property (
    @(posedge clock) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0) |=> s_axi_rdata[3:0] == $past(s_q.live))
    else $error("live bits wrong");

  chk_read_flag_bits: assert property (
    @(posedge clock) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS)
    |=> s_axi_rdata[7:4] == $past(s_q.flags) && s_axi_rdata[31:8] == 24'h0)
    else $error("flag bits wrong");

  chk_read_clears_flags: assert property (
    @(posedge clock) disable iff (rst)
    (status_read && hit == 4'h0) |=> s_q.flags == 4'h0)
    else $error("read did not clear");

  chk_set_wins: assert property (
    @(posedge clock) disable iff (rst)
    (status_read && hit != 4'h0) |=> s_q.flags == $past(hit))
    else $error("set lost to clear");

  chk_flags_sticky: assert property (
    @(posedge clock) disable iff (rst)
    !status_read |=> (s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
    else $error("flag lost without read");

  chk_irq_vector_bit: assert property (
    @(posedge clock) disable iff (rst)
    high_priority_irq_vector == {5'h0, irq_request, 2'h0})
    else $error("irq vector wrong");

  chk_edge_two_stage: assert property (
    @(posedge clock) disable iff (rst)
    s_q.control[0] ##1 s_q.control[0] |-> s_q.live == $past(s_q.sync2))
    else $error("live not sync");

  chk_sync_chain: assert property (
    @(posedge clock) disable iff (rst)
    1'b1 |=> s_q.sync2 == $past(s_q.sync1))
    else $error("sync stage skipped");

  chk_reset_zero: assert property (
    @(posedge clock)
    $fell(rst) |-> s_q.control == 8'h00 && s_q.flags == 4'h0)
    else $error("reset not zero");

  chk_ctrl_write_lands: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.aw_got && s_q.w_got && !s_q.bvalid && s_q.aw_addr == ADDR_CONTROL && s_q.w_strb[0])
    |=> s_q.control == $past(s_q.w_data[7:0]))
    else $error("control write lost");

  chk_ctrl_stable: assert property (
    @(posedge clock) disable iff (rst)
    !(s_q.aw_got && s_q.w_got && !s_q.bvalid) |=> $stable(s_q.control))
    else $error("control changed unasked");

  chk_write_answer: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.aw_got && s_q.w_got && !s_q.bvalid) |=> s_axi_bvalid)
    else $error("write not answered");

  chk_write_resp_code: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    |=> s_axi_bresp == (reg_mapped($past(s_q.aw_addr)) ? RESP_OKAY : RESP_SLVERR))
    else $error("write response wrong");

  chk_bvalid_holds: assert property (
    @(posedge clock) disable iff (rst)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  chk_read_answer: assert property (
    @(posedge clock) disable iff (rst)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read not answered");

  chk_rvalid_holds: assert property (
    @(posedge clock) disable iff (rst)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");

  chk_unmapped_read_err: assert property (
    @(posedge clock) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && !reg_mapped(s_axi_araddr))
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  chk_ctrl_readback: assert property (
    @(posedge clock) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_CONTROL)
    |=> s_axi_rdata == {24'h0, $past(s_q.control)} && s_axi_rresp == RESP_OKAY)
    else $error("control readback wrong");

  cov_irq_raised: cover property (
    @(posedge clock) disable iff (rst) $rose(irq_request));
  cov_read_clear: cover property (
    @(posedge clock) disable iff (rst) status_read && irq_request);
  cov_set_and_clear: cover property (
    @(posedge clock) disable iff (rst) status_read && hit != 4'h0);
  cov_fall_event: cover property (
    @(posedge clock) disable iff (rst) hit[0] && !s_q.control[5]);
  cov_read_refused: cover property (
    @(posedge clock) disable iff (rst) s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // comparator_irq_control
`default_nettype wire

// ---- verif/comparator_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module comparator_model (
  // clock and power
  input wire logic clock,
  input wire logic power_en,
  // analog levels and outputs
  input wire logic [3:0] level,
  output var logic [3:0] comparator_out = 4'h0
);
  // an unpowered comparator gives no valid result, so the lines wander every cycle
  always @(posedge clock) begin
    comparator_out <= power_en ? level : ~comparator_out;
  end
endmodule // comparator_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cmp_irq_pkg::*;
  logic clock = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, lv = 4'h0;
  logic [31:0] wdata = 32'h0, d;
  logic [1:0] r;
  wire logic awready, wready, bvalid, arready, rvalid, pwr, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0] vec;
  wire logic [3:0] cmp;
  int n_errors = 0, total_checks = 0;
  always #5 clock = ~clock;
  comparator_model pm (.clock(clock), .power_en(pwr), .level(lv), .comparator_out(cmp));
  comparator_irq_control dut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator_out(cmp),
    .comparator_power_en(pwr), .irq_request(irq), .high_priority_irq_vector(vec));
  task ck(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask
  // both channels offered together; each released on its own acceptance
  task wr(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 0;
    tw = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ta && tw)) begin
      @(posedge clock);
      ta = ta | awready;
      tw = tw | wready;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    while (!bvalid) @(posedge clock);
    r = bresp;
  endtask
  task rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clock); while (!arready);
    arvalid <= 0;
    do @(posedge clock); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task summarize;
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    rd(ADDR_STATUS); ck(d, 0);
    rd(ADDR_CONTROL); ck(d, 0);
    ck(pwr, 0);
    wr(ADDR_CONTROL, 32'he1);
    ck(r, RESP_OKAY);
    ck(pwr, 1);
    repeat (8) @(posedge clock);
    rd(ADDR_STATUS);
    for (int m = 1; m >= 0; m--) begin
      wr(ADDR_CONTROL, m ? 32'hff : 32'h1f);
      rd(ADDR_CONTROL); ck(d, m ? 32'hff : 32'h1f);
      for (int i = 0; i < 4; i++) begin
        lv <= 4'h1 << i;
        repeat (6) @(posedge clock);
        ck(irq, m);
        ck(vec, m ? 8'h04 : 8'h00);
        rd(ADDR_STATUS); ck(d, (1 << i) | (m ? 16 << i : 0));
        ck(irq, 0);
        lv <= 4'h0;
        repeat (6) @(posedge clock);
        rd(ADDR_STATUS); ck(d, m ? 0 : 16 << i);
        rd(ADDR_STATUS); ck(d, 0);
      end
    end
    // channel 0 on rising, the rest on falling: each select acts alone
    wr(ADDR_CONTROL, 32'h3f);
    lv <= 4'hf;
    repeat (6) @(posedge clock);
    rd(ADDR_STATUS); ck(d, 32'h1f);
    lv <= 4'h0;
    repeat (6) @(posedge clock);
    rd(ADDR_STATUS); ck(d, 32'he0);
    wr(ADDR_CONTROL, 32'he1);
    lv <= 4'hf;
    repeat (6) @(posedge clock);
    rd(ADDR_STATUS); ck(d, 32'h0f);
    ck(irq, 0);
    wr(ADDR_STATUS, 32'hff); ck(r, RESP_OKAY);
    rd(ADDR_CONTROL); ck(d, 32'he1);
    wr(ADDR_CONTROL, 32'h0);
    ck(pwr, 0);
    wr(4'h8, 32'h0); ck(r, RESP_SLVERR);
    rd(4'h8); ck(r, RESP_SLVERR);
    ck(d, 0);
    summarize;
  end
endmodule // tb
`default_nettype wire
